// ==== src/bsf_bus_cycle.sv ====
// One asynchronous flash bus cycle: select, strobe, release
`timescale 1ns/100ps
module bsf_bus_cycle (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic isRead,
  input wire bsf_pkg::bsf_step_t step,
  input wire logic [15:0] dataIn,
  output bsf_pkg::bsf_pins_t pins,
  output logic done,
  output logic [15:0] rdata
);
  import bsf_pkg::*;

  // Gray along setup, strobe, hold, idle
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_SETUP = 2'b01,
    CY_STROBE = 2'b11,
    CY_HOLD = 2'b10
  } bsf_cy_t;

  bsf_cy_t state_q; // Cycle phase
  logic [3:0] cnt_q; // Strobe length left
  logic isRead_q; // Direction of the cycle in flight

  // ==========================================================
  // Cycle sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CY_IDLE;
      pins <= PINS_IDLE;
      cnt_q <= 4'h0;
      isRead_q <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else if (ce) begin
      done <= 1'b0;
      case (state_q)
        CY_IDLE: begin
          // Address and data settle before any strobe falls
          if (start) begin
            pins.addr <= step.addr;
            pins.dataLinesOut <= step.data;
            pins.chipEnN <= 1'b0;
            pins.dataLinesOe <= ~isRead;
            isRead_q <= isRead;
            state_q <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          pins.writeEnN <= isRead_q;
          pins.outEnN <= ~isRead_q;
          cnt_q <= isRead_q ? RD_CYC : WR_CYC;
          state_q <= CY_STROBE;
        end
        CY_STROBE: begin
          // Read strobe is stretched to cover synchroniser delay
          if (cnt_q == 4'h1) begin
            if (isRead_q) begin
              rdata <= dataIn;
            end
            pins.writeEnN <= 1'b1;
            pins.outEnN <= 1'b1;
            state_q <= CY_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        CY_HOLD: begin
          // Data held past the write strobe's rise, then deselect
          pins.chipEnN <= 1'b1;
          pins.dataLinesOe <= 1'b0;
          done <= 1'b1;
          state_q <= CY_IDLE;
        end
        default: begin
          state_q <= CY_IDLE;
        end
      endcase
    end
  end

  chk_no_contention: assert property (@(posedge clk) disable iff (rst)
    !(pins.writeEnN == 1'b0 && pins.outEnN == 1'b0) &&
    (!pins.dataLinesOe || pins.outEnN))
    else $error("both strobes low or data driven with output on");

  // Strobe lasts one cycle, then data and select outlive its rise
  chk_write_select: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.writeEnN) |-> !pins.chipEnN && pins.dataLinesOe
      ##1 pins.writeEnN && !pins.chipEnN && pins.dataLinesOe)
    else $error("write strobe without select, data or hold");

endmodule : bsf_bus_cycle

// ==== src/bsf_host.sv ====
// Host controller: APB registers, command sequencer, flash pins
`timescale 1ns/100ps

// Notes on behaviour
// - commands go out as ordinary write cycles
// - bypass program two writes, otherwise four
// - completion via ready pin or toggle bit
// - suspend and resume writes allowed mid-erase
// - deselected device sits in standby
// - separate strobes, no data bus contention
module bsf_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output bsf_pkg::bsf_pins_t flashPins,
  input wire logic [15:0] dataLinesIn,
  input wire logic readyBusyN,
  output logic resetN,
  output logic bootGuardN,
  output logic byteModeN
);
  import bsf_pkg::*;

  // Gray along idle, issue, wait cycle, wait device
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_ISSUE = 3'b001,
    SQ_WAITC = 3'b011,
    SQ_WAITDEV = 3'b010,
    SQ_RESET = 3'b110
  } bsf_sq_t;

  // ==========================================================
  // Registers and state
  logic [31:0] ctrl_q; // Mode bits
  logic [31:0] addr_q; // Target address
  logic [31:0] data_q; // Data for the final write
  logic [15:0] rdLast_q; // Last data read from the flash
  logic [31:0] codes_q; // Command byte values
  logic [31:0] unlock_q; // Unlock addresses
  logic [ST_W-1:0] status_q; // Sticky events
  logic [ST_W-1:0] mask_q; // Interrupt mask
  bsf_sq_t state_q; // Sequencer state
  bsf_op_t op_q; // Operation in flight
  logic bypass_q; // Bypass mode latched at start
  logic [2:0] stepIdx_q; // Current step of the sequence
  logic [2:0] wrCnt_q; // Write cycles issued this operation
  logic [3:0] waitCnt_q; // Settling or reset pulse counter
  logic tglHave_q; // First toggle sample taken
  logic tglPrev_q; // Previous toggle bit sample
  logic tglPend_q; // Status read in flight
  logic cycStart_q; // Pulse to the bus cycle engine
  logic cycRead_q; // Direction for the engine
  logic readySync; // Synchronised ready/busy pin
  logic [15:0] dataSync; // Synchronised data lines
  logic cycDone; // Engine finished a cycle
  logic [15:0] cycData; // Engine read data
  logic setupPh; // APB setup cycle seen
  logic wrAcc; // APB write takes effect this edge
  logic rdAcc; // APB read completes this edge
  logic cmdReq; // Software asks for an operation
  logic cmdOk; // Request is accepted
  logic evDone; // Completion event
  logic evRead; // Single cycle event
  logic evRefused; // Refusal event
  logic lastStep; // Current step is the last one
  bsf_op_t cmdOp; // Requested operation
  bsf_step_t curStep; // Address and data of current step

  assign setupPh = psel && !penable;
  assign wrAcc = psel && penable && pready && pwrite;
  assign rdAcc = psel && penable && pready && !pwrite;
  assign cmdOp = bsf_op_t'(pwdata[3:0]);
  assign cmdReq = wrAcc && paddr == REG_CMD && cmdOp != OP_NONE;

  // ==========================================================
  // Pin inputs cross through two flops before any use
  bsf_sync #(.W(1), .RST_VAL(1'b1)) u_syncReady (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async(readyBusyN),
    .sync(readySync)
  );

  bsf_sync #(.W(16), .RST_VAL(16'h0000)) u_syncData (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async(dataLinesIn),
    .sync(dataSync)
  );

  // ==========================================================
  // Acceptance: program and erase wait for a ready device
  always_comb begin
    cmdOk = 1'b0;
    case (cmdOp)
      OP_PROGRAM, OP_ERASE, OP_READ: begin
        cmdOk = state_q == SQ_IDLE && readySync;
      end
      OP_WRITE: begin
        // Suspend or resume may interrupt the completion wait
        cmdOk = state_q == SQ_IDLE || state_q == SQ_WAITDEV;
      end
      OP_RESET: begin
        cmdOk = 1'b1;
      end
      default: begin
        cmdOk = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Step table for each command sequence
  function automatic bsf_step_t stepFor(bsf_op_t op, logic byp,
      logic [2:0] idx);
    bsf_step_t u1;
    bsf_step_t u2;
    bsf_step_t fin;
    u1 = '{{5'h00, unlock_q[15:0]}, {8'h00, codes_q[7:0]}};
    u2 = '{{5'h00, unlock_q[31:16]}, {8'h00, codes_q[15:8]}};
    fin = '{addr_q[20:0], data_q[15:0]};
    stepFor = fin;
    if (op == OP_PROGRAM && byp) begin
      if (idx == 3'h0) stepFor = '{addr_q[20:0], {8'h00, codes_q[23:16]}};
    end else if (op == OP_PROGRAM) begin
      case (idx)
        3'h0: stepFor = u1;
        3'h1: stepFor = u2;
        3'h2: stepFor = '{u1.addr, {8'h00, codes_q[23:16]}};
        default: stepFor = fin;
      endcase
    end else if (op == OP_ERASE) begin
      // Final write picks chip or sector erase
      case (idx)
        3'h0, 3'h3: stepFor = u1;
        3'h1, 3'h4: stepFor = u2;
        3'h2: stepFor = '{u1.addr, {8'h00, codes_q[31:24]}};
        default: stepFor = fin;
      endcase
    end
  endfunction : stepFor

  function automatic logic [2:0] stepsFor(bsf_op_t op, logic byp);
    stepsFor = SINGLE_STEPS;
    if (op == OP_PROGRAM) stepsFor = byp ? BYPASS_STEPS : PROG_STEPS;
    if (op == OP_ERASE) stepsFor = ERASE_STEPS;
  endfunction : stepsFor

  // The step table reads registers beyond its arguments, so a process
  // keeps it current when only an address or code changes
  always_comb begin
    curStep = stepFor(op_q, bypass_q, stepIdx_q);
  end
  assign lastStep = stepIdx_q == stepsFor(op_q, bypass_q) - 3'h1;

  // ==========================================================
  // Bus cycle engine
  bsf_bus_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(cycStart_q),
    .isRead(cycRead_q),
    .step(tglPend_q ? bsf_step_t'{addr_q[20:0], 16'h0000} : curStep),
    .dataIn(dataSync),
    .pins(flashPins),
    .done(cycDone),
    .rdata(cycData)
  );

  // ==========================================================
  // Command sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SQ_IDLE;
      op_q <= OP_NONE;
      bypass_q <= 1'b0;
      stepIdx_q <= 3'h0;
      wrCnt_q <= 3'h0;
      waitCnt_q <= 4'h0;
      tglHave_q <= 1'b0;
      tglPrev_q <= 1'b0;
      tglPend_q <= 1'b0;
      cycStart_q <= 1'b0;
      cycRead_q <= 1'b0;
      resetN <= 1'b1;
      rdLast_q <= 16'h0000;
    end else if (ce) begin
      cycStart_q <= 1'b0;
      if (cmdReq && cmdOk && cmdOp == OP_RESET) begin
        // Pulse the device reset pin; pending cycle finishes alone
        resetN <= 1'b0;
        waitCnt_q <= RST_CYC;
        state_q <= SQ_RESET;
      end else if (cmdReq && cmdOk) begin
        op_q <= cmdOp;
        bypass_q <= ctrl_q[CTRL_BYPASS];
        stepIdx_q <= 3'h0;
        wrCnt_q <= 3'h0;
        tglPend_q <= 1'b0;
        state_q <= SQ_ISSUE;
      end else begin
        case (state_q)
          SQ_ISSUE: begin
            cycStart_q <= 1'b1;
            cycRead_q <= op_q == OP_READ;
            state_q <= SQ_WAITC;
          end
          SQ_WAITC: begin
            if (cycDone) begin
              if (!cycRead_q) wrCnt_q <= wrCnt_q + 3'h1;
              if (!lastStep) begin
                stepIdx_q <= stepIdx_q + 3'h1;
                state_q <= SQ_ISSUE;
              end else if (op_q == OP_PROGRAM || op_q == OP_ERASE) begin
                // Device runs its embedded routine now
                waitCnt_q <= BUSY_CYC;
                tglHave_q <= 1'b0;
                state_q <= SQ_WAITDEV;
              end else begin
                if (cycRead_q) rdLast_q <= cycData;
                state_q <= SQ_IDLE;
              end
            end
          end
          SQ_WAITDEV: begin
            // Ready pin needs time to fall, so hold off first
            if (waitCnt_q != 4'h0) begin
              waitCnt_q <= waitCnt_q - 4'h1;
            end else if (!ctrl_q[CTRL_TOGGLE]) begin
              if (readySync) state_q <= SQ_IDLE;
            end else if (!tglPend_q) begin
              // Toggle bit stops toggling when the routine ends
              tglPend_q <= 1'b1;
              cycStart_q <= 1'b1;
              cycRead_q <= 1'b1;
            end else if (cycDone) begin
              tglPend_q <= 1'b0;
              tglHave_q <= 1'b1;
              tglPrev_q <= cycData[TOGGLE_BIT];
              rdLast_q <= cycData;
              if (tglHave_q && tglPrev_q == cycData[TOGGLE_BIT]) begin
                state_q <= SQ_IDLE;
              end
            end
          end
          SQ_RESET: begin
            if (waitCnt_q == 4'h1) begin
              resetN <= 1'b1;
              state_q <= SQ_IDLE;
            end
            waitCnt_q <= waitCnt_q - 4'h1;
          end
          default: begin
            state_q <= SQ_IDLE;
          end
        endcase
      end
    end
  end

  assign evDone = state_q == SQ_WAITDEV && (waitCnt_q == 4'h0) &&
    (ctrl_q[CTRL_TOGGLE] ? (tglPend_q && cycDone && tglHave_q &&
    tglPrev_q == cycData[TOGGLE_BIT]) : readySync) &&
    !(cmdReq && cmdOk);
  assign evRead = state_q == SQ_WAITC && cycDone && lastStep &&
    (op_q == OP_READ || op_q == OP_WRITE) && !(cmdReq && cmdOk);
  assign evRefused = cmdReq && !cmdOk;

  // ==========================================================
  // Software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      addr_q <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
      codes_q <= CODES_RST;
      unlock_q <= UNLOCK_RST;
      mask_q <= MASK_RST;
    end else if (ce && wrAcc) begin
      case (paddr)
        REG_CTRL: ctrl_q <= {27'h0, pwdata[4:0]};
        REG_ADDR: addr_q <= {11'h000, pwdata[20:0]};
        REG_DATA: data_q <= {16'h0000, pwdata[15:0]};
        REG_CODES: codes_q <= pwdata;
        REG_UNLOCK: unlock_q <= pwdata;
        REG_MASK: mask_q <= pwdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Read clears only the bits it returned, so an event landing on the
  // setup edge is not lost; a fresh event always wins
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= '0;
    end else if (ce) begin
      status_q <= ((rdAcc && paddr == REG_STATUS) ?
        (status_q & ~prdata[ST_W-1:0]) : status_q) |
        {evRefused, evRead, evDone};
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge clk) begin
    if (rst) irq <= 1'b0;
    else if (ce) irq <= |(status_q & mask_q);
  end

  // Static pins from the mode register
  always_ff @(posedge clk) begin
    if (rst) begin
      bootGuardN <= 1'b0;
      byteModeN <= 1'b1;
    end else if (ce) begin
      bootGuardN <= ctrl_q[CTRL_GUARD_OFF];
      byteModeN <= ~ctrl_q[CTRL_BYTE];
    end
  end

  // ==========================================================
  // APB slave: no wait states, data captured in setup
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setupPh;
      pslverr <= 1'b0;
      if (setupPh) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          REG_CTRL: prdata <= ctrl_q;
          REG_CMD: prdata <= {25'h0, state_q, op_q};
          REG_ADDR: prdata <= addr_q;
          REG_DATA: prdata <= {16'h0000, rdLast_q};
          REG_STATUS: prdata <= {29'h0, status_q};
          REG_MASK: prdata <= {29'h0, mask_q};
          REG_CODES: prdata <= codes_q;
          REG_UNLOCK: prdata <= unlock_q;
          REG_PINS: prdata <= {30'h0, resetN, readySync};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  chk_prog_count: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SQ_WAITC && cycDone && lastStep &&
      op_q == OP_PROGRAM) |->
    (wrCnt_q + 3'h1 == (bypass_q ? 3'h2 : 3'h4)))
    else $error("program sequence has wrong number of writes");

  chk_busy_refuse: assert property (@(posedge clk) disable iff (rst)
    (cmdReq && (cmdOp == OP_PROGRAM || cmdOp == OP_ERASE) &&
      (state_q != SQ_IDLE || !readySync))
    |=> status_q[ST_REFUSED] && $stable(op_q))
    else $error("program or erase accepted while device busy");

  chk_done_ready: assert property (@(posedge clk) disable iff (rst)
    (ce && $rose(status_q[ST_DONE]) && !$past(ctrl_q[CTRL_TOGGLE]))
    |-> $past(readySync) && $past(state_q) == SQ_WAITDEV)
    else $error("done reported while ready pin low");

  chk_suspend_ok: assert property (@(posedge clk) disable iff (rst)
    (ce && cmdReq && cmdOp == OP_WRITE && state_q == SQ_WAITDEV)
    |=> state_q == SQ_ISSUE ##1 state_q == SQ_WAITC)
    else $error("suspend or resume write not issued during erase");

  chk_standby_sel: assert property (@(posedge clk) disable iff (rst)
    (state_q == SQ_IDLE && $past(state_q) == SQ_IDLE &&
      $past(state_q, 2) == SQ_IDLE) |-> flashPins.chipEnN)
    else $error("device selected while controller idle");

endmodule : bsf_host

// ==== src/bsf_pkg.sv ====
// Shared constants and types for the boot-sector flash host controller
package bsf_pkg;

  // ==========================================================
  // APB register map (byte offsets, one word each)
  localparam logic [7:0] REG_CTRL = 8'h00; // Mode and pin control
  localparam logic [7:0] REG_CMD = 8'h04; // Operation start / state
  localparam logic [7:0] REG_ADDR = 8'h08; // Target flash address
  localparam logic [7:0] REG_DATA = 8'h0c; // Write data / last read data
  localparam logic [7:0] REG_STATUS = 8'h10; // Sticky events, read clears
  localparam logic [7:0] REG_MASK = 8'h14; // Interrupt mask
  localparam logic [7:0] REG_CODES = 8'h18; // Command byte values
  localparam logic [7:0] REG_UNLOCK = 8'h1c; // Two unlock addresses
  localparam logic [7:0] REG_PINS = 8'h20; // Live pin view

  // ==========================================================
  // Field positions
  localparam int CTRL_BYTE = 0; // Byte-wide data bus
  localparam int CTRL_BYPASS = 1; // Unlock bypass is active
  localparam int CTRL_TOGGLE = 2; // Poll toggle bit, not ready pin
  localparam int CTRL_GUARD_OFF = 3; // Boot-guard pin driven high
  localparam int CTRL_STANDBY = 4; // Stored in ctrl_q, drives no pin
  localparam int ST_DONE = 0; // Program/erase completed
  localparam int ST_READ = 1; // Single cycle finished
  localparam int ST_REFUSED = 2; // Command refused while busy
  localparam int ST_W = 3; // Status width
  localparam int TOGGLE_BIT = 6; // Toggle status bit lane
  localparam int POLL_BIT = 7; // Polling status bit lane

  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CODES_RST = 32'h0000_0000;
  localparam logic [31:0] UNLOCK_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  // ==========================================================
  // Sequence lengths in bus cycles
  localparam logic [2:0] PROG_STEPS = 3'h4; // Unlocked program
  localparam logic [2:0] BYPASS_STEPS = 3'h2; // Program in bypass mode
  localparam logic [2:0] ERASE_STEPS = 3'h6; // Chip or sector erase
  localparam logic [2:0] SINGLE_STEPS = 3'h1; // Raw read or write

  // ==========================================================
  // Timing in nanoseconds and derived cycle counts at 10 MHz
  localparam int CLK_NS = 100;
  localparam int STROBE_NS = 100; // Least write-strobe low time
  localparam int ACCESS_NS = 200; // Least output-enable to data
  localparam int RESET_NS = 500; // Least reset pulse
  localparam int BUSY_NS = 500; // Least wait before status checks
  localparam int SYNC_STAGES = 2; // Input synchroniser depth
  localparam int WR_CYC_I = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC_I = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC_I = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC_I = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] WR_CYC = 4'(WR_CYC_I < 1 ? 1 : WR_CYC_I);
  localparam logic [3:0] RD_CYC = 4'(RD_CYC_I + SYNC_STAGES);
  localparam logic [3:0] RST_CYC = 4'(RST_CYC_I < 1 ? 1 : RST_CYC_I);
  localparam logic [3:0] BUSY_CYC = 4'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);

  // ==========================================================
  // Operations software can start through REG_CMD
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_READ = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_ERASE = 4'h3,
    OP_WRITE = 4'h4,
    OP_RESET = 4'h5
  } bsf_op_t;

  // Flash bus pins driven by the controller
  typedef struct packed {
    logic chipEnN; // Chip select, low active
    logic writeEnN; // Write strobe, low active
    logic outEnN; // Output drive enable, low active
    logic [20:0] addr; // Word address, bit 0 is A-1 in byte mode
    logic [15:0] dataLinesOut; // Data lines driven value
    logic dataLinesOe; // High while we drive the data lines
  } bsf_pins_t;

  localparam bsf_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 21'h0, 16'h0, 1'b0};

  // One bus cycle of a command sequence
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
  } bsf_step_t;

endpackage : bsf_pkg

// ==== src/bsf_sync.sv ====
// Two-stage synchroniser for inputs from the flash pins
`timescale 1ns/100ps
module bsf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] async,
  output logic [W-1:0] sync
);

  logic [W-1:0] meta_q; // First stage, read only by second stage

  // ==========================================================
  // Both stages
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync <= RST_VAL;
    end else if (ce) begin
      meta_q <= async;
      sync <= meta_q;
    end
  end

endmodule : bsf_sync

// ==== tb/boot_sector_flash_command_core_tb.sv ====
// Self-checking bench for the boot-sector flash host controller
`timescale 1ns/100ps
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module boot_sector_flash_command_core_tb;
  import bsf_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready;
  logic [7:0] paddr = 0, a;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] dq, d;
  logic pslverr, irq, readyBusyN, resetN, bootGuardN, byteModeN;
  bsf_pins_t flashPins;
  logic [32:0] expQ [$]; // Expected {pslverr, prdata} per read
  logic [32:0] ex; // Oldest note, popped once per read
  int failures = 0, cmp_count = 0, seed = 30, wcnt = 0;
  always #50 clk = ~clk;
  bsf_host bsf_host_inst (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .flashPins(flashPins), .readyBusyN(readyBusyN), .resetN(resetN),
    .dataLinesIn(flashPins.dataLinesOe ? flashPins.dataLinesOut : dq),
    .bootGuardN(bootGuardN), .byteModeN(byteModeN));
  bsf_flash_model bsf_flash_model_inst (.pins(flashPins), .resetN(resetN),
    .bootGuardN(bootGuardN), .readyBusyN(readyBusyN), .dq(dq));
  // Strobe count shows how many write cycles a sequence took
  always @(posedge flashPins.writeEnN) wcnt++;
  // ==========================================
  // Watcher: each finished read takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      ex = expQ.pop_front();
      `CMP({pslverr, prdata}, ex)
    end
  end
  // APB transfer; holds until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] ad, input logic w,
      input logic [31:0] wd);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [32:0] e);
    expQ.push_back(e);
    apb(ad, 0, 0);
  endtask : rd
  // Bounded wait for the interrupt line
  task automatic wirq();
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (irq !== 1'b1 && n++ < 3000) @(negedge clk);
    if (n >= 3000) failures++;
  endtask : wirq
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rd(REG_CTRL, 33'h0);
    rd(REG_STATUS, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    apb(REG_CODES, 1, 32'h80a055aa);
    apb(REG_UNLOCK, 1, 32'h02aa0555);
    apb(REG_MASK, 1, 32'h7);
    // Plain, toggle-polled, bypass and both program flows
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      a = 8'($random(seed)) | 8'h01;
      apb(REG_CTRL, 1, {29'h1, i[0], i[1], 1'b0});
      apb(REG_ADDR, 1, {24'h0, a});
      apb(REG_DATA, 1, {16'h0, d});
      wcnt = 0;
      apb(REG_CMD, 1, 32'(OP_PROGRAM));
      apb(REG_CMD, 1, 32'(OP_PROGRAM)); // Refused: still busy
      wirq();
      rd(REG_STATUS, 33'h4);
      wirq();
      rd(REG_STATUS, 33'h1);
      `CMP(wcnt, i[1] ? 2 : 4)
      apb(REG_CMD, 1, 32'(OP_READ));
      wirq();
      rd(REG_STATUS, 33'h2);
      rd(REG_DATA, {17'h0, d});
    end
    // Erase, then a suspend write while the device is still busy
    apb(REG_CTRL, 1, 32'h8);
    apb(REG_ADDR, 1, {24'h0, a});
    apb(REG_DATA, 1, 32'h30);
    apb(REG_CMD, 1, 32'(OP_ERASE));
    repeat (40) @(posedge clk);
    apb(REG_CMD, 1, 32'(OP_WRITE));
    wirq();
    rd(REG_STATUS, 33'h2);
    repeat (40) @(posedge clk);
    apb(REG_CMD, 1, 32'(OP_READ));
    wirq();
    rd(REG_STATUS, 33'h2);
    rd(REG_DATA, 33'hffff);
    // Guard low, byte mode: boot word stays erased
    apb(REG_CTRL, 1, 32'h1);
    apb(REG_ADDR, 1, 32'h0);
    apb(REG_CMD, 1, 32'(OP_PROGRAM));
    wirq();
    rd(REG_STATUS, 33'h1);
    `CMP(byteModeN, 1'b0)
    apb(REG_CMD, 1, 32'(OP_READ));
    wirq();
    rd(REG_STATUS, 33'h2);
    rd(REG_DATA, 33'hffff);
    apb(REG_CMD, 1, 32'(OP_RESET));
    rd(REG_PINS, 33'h1);
    repeat (12) @(posedge clk);
    rd(REG_PINS, 33'h3);
    tally_and_finish();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule : boot_sector_flash_command_core_tb

// ==== tb/bsf_flash_model.sv ====
// Behavioural flash device answering the host controller's pins
`timescale 1ns/100ps
module bsf_flash_model (
  input wire bsf_pkg::bsf_pins_t pins,
  input wire logic resetN,
  input wire logic bootGuardN,
  output logic readyBusyN,
  output logic [15:0] dq
);
  import bsf_pkg::*;
  logic [15:0] mem [256]; // Array slice, starts erased
  logic [15:0] rdQ; // Value a read returns now
  logic [7:0] prevQ = 8'h00; // Previous command byte
  logic tog = 1'b0; // Toggle status bit
  initial begin
    readyBusyN = 1'b1;
    foreach (mem[i]) mem[i] = 16'hffff;
  end
  // ==========================================
  // Writes latch address and data on strobe rise
  always @(posedge pins.writeEnN or negedge resetN) begin
    if (!resetN) begin
      prevQ = 8'h00; // Abort, back to array read
      readyBusyN = 1'b1;
    end else if (!pins.chipEnN) begin
      if (prevQ == 8'ha0) begin
        // Boot word refused while guard pin low
        if (bootGuardN || pins.addr[7:0] != 8'h00) begin
          mem[pins.addr[7:0]] = pins.dataLinesOut;
          readyBusyN = 1'b0;
        end
        prevQ = 8'h00;
      end else begin
        if (prevQ == 8'h55 && pins.dataLinesOut[7:0] == 8'h30) begin
          foreach (mem[i]) begin
            if (bootGuardN || i != 0) mem[i] = 16'hffff;
          end
          readyBusyN = 1'b0;
        end
        prevQ = pins.dataLinesOut[7:0];
      end
      // Slow answer: busy for 30 host cycles
      if (!readyBusyN) readyBusyN <= #3000 1'b1;
    end
  end
  // Each read while busy flips the toggle bit
  always @(negedge pins.outEnN) tog = ~tog;
  assign rdQ = readyBusyN ? mem[pins.addr[7:0]] : {9'h0, tog, 6'h0};
  // Released lines show the inverse, never a stale copy
  assign dq = (!pins.chipEnN && !pins.outEnN) ? rdQ : ~rdQ;
endmodule : bsf_flash_model
